// [rtl/sipes_pkg.sv]
// Purpose: constants and types of the sample input port and exponent scaler
// Assumes: one 10 MHz clock, classic Wishbone register access
// Notes: register offsets are indices; the byte address is four times that
package sipes_pkg;
    localparam int MANT_W = 16; // mantissa width
    localparam int EXP_W = 3; // exponent and bias width
    localparam int INTEG_W = 40; // first integrator width
    localparam int ADR_W = 12; // wishbone byte address width
    localparam int IDX_W = 10; // register index width
    localparam logic [IDX_W-1:0] MODE_IDX = 10'h300; // input mode register
    localparam logic [IDX_W-1:0] CTRL_IDX = 10'h305; // exponent control
    localparam logic [IDX_W-1:0] STAT_IDX = 10'h306; // status, read only
    localparam int BIAS_LSB = 5; // bias field position
    localparam int DIR_BIT = 4; // direction flag position
    localparam int STAT_CNT_LSB = 16; // accepted count field position
    localparam logic [EXP_W-1:0] EXP_TOP = 3'h7; // inverted exponent base
    localparam logic [7:0] CTRL_RST = 8'h00; // control reset value
    localparam int CLK_PERIOD_NS = 100; // processing clock period

    // input mode codes
    typedef enum logic [1:0] {
        SIPES_SINGLE_REAL = 2'b00,
        SIPES_DIVERSITY = 2'b01,
        SIPES_COMPLEX = 2'b10,
        SIPES_RESERVED = 2'b11
    } sipes_mode_e;

    // one captured input word
    typedef struct packed {
        logic signed [MANT_W-1:0] mant;
        logic [EXP_W-1:0] gain_range_code;
        logic strobe;
    } sipes_sample_s;

    // first integrator sums
    typedef struct packed {
        logic signed [INTEG_W-1:0] i_sum;
        logic signed [INTEG_W-1:0] q_sum;
    } sipes_integ_s;
endpackage

// [rtl/sipes_top.sv]
// Purpose: input port, exponent scaler and first integrator of the receiver
// Assumes: adc pins and oscillator words are synchronous to clk_i
// Notes: three stages: capture, scale and qualify, integrate
`timescale 1ns/1ns
module sipes_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sipes_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire sipes_pkg::sipes_sample_s pin_i,
    input wire logic signed [sipes_pkg::MANT_W-1:0] cos_i,
    input wire logic signed [sipes_pkg::MANT_W-1:0] sin_i,
    output logic signed [sipes_pkg::MANT_W-1:0] sample_o,
    output logic sample_valid_o,
    output logic channel_a_o,
    output sipes_pkg::sipes_integ_s integ_o,
    output logic integ_done_o
);
    import sipes_pkg::*;

    // registers
    sipes_mode_e mode_reg; // input mode
    logic [EXP_W-1:0] exponent_bias_reg; // bias added to exponent
    logic exponent_direction_flag_reg; // invert exponent direction
    sipes_sample_s in_reg; // pins latched on the rising edge
    logic prev_strobe_reg; // strobe level of the previous capture
    logic i_held_reg; // in-phase sample waits for its partner
    logic [15:0] acc_cnt_reg; // accepted samples, wraps
    logic [31:0] rd_data_reg; // read data
    logic ack_reg; // bus answer
    logic signed [MANT_W-1:0] sample_reg; // scaled sample
    logic valid_reg; // scaled sample is new
    logic chan_a_reg; // tag of the scaled sample
    sipes_integ_s integ_reg; // first integrator sums
    logic done_reg; // sums complete for downstream

    // bus decode
    wire logic [IDX_W-1:0] idx_w = wb_adr_i[ADR_W-1:2];
    wire logic bus_req_w = wb_cyc_i && wb_stb_i && !ack_reg;
    wire logic wr_w = bus_req_w && wb_we_i && wb_sel_i[0];
    wire logic wr_mode_w = wr_w && (idx_w == MODE_IDX);
    wire logic wr_ctrl_w = wr_w && (idx_w == CTRL_IDX);

    // read mux; unmapped indices read as zero
    wire logic [31:0] mode_rd_w = {30'h0, mode_reg};
    wire logic [31:0] ctrl_rd_w = {24'h0, exponent_bias_reg,
        exponent_direction_flag_reg, 4'h0};
    wire logic [31:0] stat_rd_w = {acc_cnt_reg, 14'h0, chan_a_reg,
        i_held_reg};
    wire logic [31:0] rd_mux_w = (idx_w == MODE_IDX) ? mode_rd_w :
        (idx_w == CTRL_IDX) ? ctrl_rd_w :
        (idx_w == STAT_IDX) ? stat_rd_w : 32'h0;

    // mode decode; the reserved code behaves as single real
    wire logic single_w = (mode_reg == SIPES_SINGLE_REAL) ||
        (mode_reg == SIPES_RESERVED);
    wire logic cplx_w = (mode_reg == SIPES_COMPLEX);

    // acceptance: enable level in single real, edge of strobe otherwise
    wire logic toggled_w = (in_reg.strobe != prev_strobe_reg);
    wire logic accept_w = single_w ? in_reg.strobe : toggled_w;

    // shift amount wraps in three bits, so the modulo is free
    wire logic [EXP_W-1:0] fwd_shift_w =
        EXP_W'(in_reg.gain_range_code + exponent_bias_reg);
    wire logic [EXP_W-1:0] inv_shift_w =
        EXP_W'(EXP_TOP - in_reg.gain_range_code + exponent_bias_reg);
    wire logic [EXP_W-1:0] shift_w = exponent_direction_flag_reg ?
        inv_shift_w : fwd_shift_w;
    // arithmetic shift keeps the sign of the mantissa
    wire logic signed [MANT_W-1:0] scaled_w = in_reg.mant >>> shift_w;

    // mixer products of the scaled sample and the oscillator
    wire logic signed [2*MANT_W-1:0] p_cos_w = sample_reg * cos_i;
    wire logic signed [2*MANT_W-1:0] p_sin_w = sample_reg * sin_i;
    wire logic signed [INTEG_W-1:0] x_cos_w = INTEG_W'(p_cos_w);
    wire logic signed [INTEG_W-1:0] x_sin_w = INTEG_W'(p_sin_w);
    // quadrature half of the complex multiply
    wire logic q_phase_w = cplx_w && !chan_a_reg;
    wire logic signed [INTEG_W-1:0] i_add_w = q_phase_w ?
        -x_sin_w : x_cos_w;
    wire logic signed [INTEG_W-1:0] q_add_w = q_phase_w ?
        x_sin_w : x_sin_w;
    wire logic signed [INTEG_W-1:0] q_term_w = q_phase_w ?
        x_cos_w : q_add_w;

    // register writes and bus answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg <= SIPES_SINGLE_REAL;
            exponent_bias_reg <= CTRL_RST[BIAS_LSB +: EXP_W];
            exponent_direction_flag_reg <= CTRL_RST[DIR_BIT];
            ack_reg <= 1'b0;
            rd_data_reg <= 32'h0;
        end else begin
            // ack lasts one cycle, so the next request waits a cycle
            ack_reg <= bus_req_w;
            if (bus_req_w) begin
                rd_data_reg <= rd_mux_w;
            end
            if (wr_mode_w) begin
                mode_reg <= sipes_mode_e'(wb_dat_i[1:0]);
            end
            if (wr_ctrl_w) begin
                exponent_bias_reg <= wb_dat_i[BIAS_LSB +: EXP_W];
                exponent_direction_flag_reg <= wb_dat_i[DIR_BIT];
            end
        end
    end

    // capture stage: every edge latches the pins, no enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_reg <= '0;
            prev_strobe_reg <= 1'b0;
        end else begin
            in_reg <= pin_i;
            prev_strobe_reg <= in_reg.strobe;
        end
    end

    // scale stage: only accepted samples move forward
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_reg <= '0;
            valid_reg <= 1'b0;
            chan_a_reg <= 1'b0;
            acc_cnt_reg <= 16'h0;
        end else begin
            valid_reg <= accept_w;
            if (accept_w) begin
                sample_reg <= scaled_w;
                chan_a_reg <= in_reg.strobe;
                acc_cnt_reg <= acc_cnt_reg + 16'h1;
            end
        end
    end

    // first integrator: real data each sample, complex over two samples
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            integ_reg <= '0;
            done_reg <= 1'b0;
            i_held_reg <= 1'b0;
        end else begin
            // a complex pair completes only on its quadrature half
            done_reg <= valid_reg && !(cplx_w && chan_a_reg);
            if (valid_reg) begin
                integ_reg.i_sum <= integ_reg.i_sum + i_add_w;
                integ_reg.q_sum <= integ_reg.q_sum + q_term_w;
                i_held_reg <= cplx_w && chan_a_reg;
            end
        end
    end

    // outputs straight from flip-flops
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rd_data_reg;
    assign sample_o = sample_reg;
    assign sample_valid_o = valid_reg;
    assign channel_a_o = chan_a_reg;
    assign integ_o = integ_reg;
    assign integ_done_o = done_reg;

    // checks on the datapath
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // forward direction, any bias
    property p_fwd_shift;
        (accept_w && !exponent_direction_flag_reg) |=>
            (sample_o == ($past(in_reg.mant) >>>
            EXP_W'($past(in_reg.gain_range_code) +
            $past(exponent_bias_reg))));
    endproperty
    a_fwd_shift: assert property (p_fwd_shift)
        else $error("forward exponent shift wrong");

    // inverted direction: code 5, zero bias shifts by two
    property p_inv_zero_bias;
        (accept_w && exponent_direction_flag_reg && exponent_bias_reg == 3'h0
            && in_reg.gain_range_code == 3'h5) |=>
            (sample_o == ($past(in_reg.mant) >>> 2));
    endproperty
    a_inv_zero_bias: assert property (p_inv_zero_bias)
        else $error("code five not attenuated by 12 dB");

    // inverted direction, bias six: code five unshifted
    property p_inv_bias6;
        (accept_w && exponent_direction_flag_reg && exponent_bias_reg == 3'h6
            && in_reg.gain_range_code == 3'h5) |=>
            (sample_o == $past(in_reg.mant));
    endproperty
    a_inv_bias6: assert property (p_inv_bias6)
        else $error("bias six does not unshift code five");

    // inverted direction, bias five: code four unshifted
    property p_inv_bias5;
        (accept_w && exponent_direction_flag_reg && exponent_bias_reg == 3'h5
            && in_reg.gain_range_code == 3'h4) |=>
            (sample_o == $past(in_reg.mant));
    endproperty
    a_inv_bias5: assert property (p_inv_bias5)
        else $error("bias five does not unshift code four");

    // single real: a sample only when the strobe was high
    property p_single_enable;
        (single_w && $past(single_w) && sample_valid_o) |->
            $past(in_reg.strobe);
    endproperty
    a_single_enable: assert property (p_single_enable)
        else $error("sample taken with strobe low");

    // edge modes: a steady strobe yields no sample
    property p_edge_only;
        (!single_w && in_reg.strobe == prev_strobe_reg) |=> !sample_valid_o;
    endproperty
    a_edge_only: assert property (p_edge_only)
        else $error("sample taken without strobe toggle");

    // diversity tag follows the strobe level
    property p_tag;
        (accept_w && mode_reg == SIPES_DIVERSITY) |=>
            (channel_a_o == $past(in_reg.strobe));
    endproperty
    a_tag: assert property (p_tag)
        else $error("channel tag wrong");

    // complex pair: in-phase holds the result, quadrature releases it
    sequence s_i_taken;
        sample_valid_o && channel_a_o && cplx_w;
    endsequence
    sequence s_q_taken;
        sample_valid_o && !channel_a_o && cplx_w;
    endsequence
    property p_cplx_hold;
        s_i_taken |=> !integ_done_o;
    endproperty
    a_cplx_hold: assert property (p_cplx_hold)
        else $error("in-phase half released early");
    property p_cplx_done;
        s_q_taken |=> integ_done_o;
    endproperty
    a_cplx_done: assert property (p_cplx_done)
        else $error("quadrature half did not complete");

    // no sample, no movement of the integrators
    property p_idle_stable;
        !sample_valid_o |=> ($stable(integ_o) && !integ_done_o);
    endproperty
    a_idle_stable: assert property (p_idle_stable)
        else $error("integrator moved without a sample");

    // single real: a high strobe always yields a sample
    property p_single_take;
        (single_w && in_reg.strobe) |=> sample_valid_o;
    endproperty
    a_single_take: assert property (p_single_take)
        else $error("strobe high but no sample");

    // edge modes: a strobe change always yields a sample
    property p_edge_take;
        (!single_w && toggled_w) |=> sample_valid_o;
    endproperty
    a_edge_take: assert property (p_edge_take)
        else $error("strobe toggled but no sample");

    // inverted direction, zero bias: code four loses one step more
    property p_inv_step;
        (accept_w && exponent_direction_flag_reg && exponent_bias_reg == 3'h0
            && in_reg.gain_range_code == 3'h4) |=>
            (sample_o == ($past(in_reg.mant) >>> 3));
    endproperty
    a_inv_step: assert property (p_inv_step)
        else $error("code four not attenuated by 18 dB");

    // scaling is arithmetic, so the sign of the mantissa survives
    property p_sign_kept;
        accept_w |=> (sample_o[MANT_W-1] == $past(in_reg.mant[MANT_W-1]));
    endproperty
    a_sign_kept: assert property (p_sign_kept)
        else $error("mantissa sign lost in scaling");

    // an in-phase half marks itself as waiting for its partner
    property p_i_waits;
        s_i_taken |=> i_held_reg;
    endproperty
    a_i_waits: assert property (p_i_waits)
        else $error("in-phase half not held for pairing");

    // real samples, either channel, complete on the next cycle
    property p_real_done;
        (sample_valid_o && !cplx_w) |=> integ_done_o;
    endproperty
    a_real_done: assert property (p_real_done)
        else $error("real sample did not reach the integrators");

    // the bus answer is a single-cycle pulse
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("bus answer held for two cycles");

    // reset clears every result; checked through reset itself
    property p_reset_clear;
        disable iff (1'b0)
            rst_i |=> (!sample_valid_o && !integ_done_o && integ_o == '0);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("reset left a result standing");
endmodule

// [verif/sipes_adc_model.sv]
// Purpose: converter model that drives the sample input pins
// Assumes: the converter sample clock is an integer fraction of clk_i
// Notes: unused edges carry inverted data so late capture shows up
`timescale 1ns/1ns
module sipes_adc_model (
    input wire logic clk_i,
    output sipes_pkg::sipes_sample_s pin_o
);
    import sipes_pkg::*;
    initial pin_o = '0; // strobe low until the first sample
    // one sample, valid on its first edge, inverted for the other div - 1 edges
    task automatic send(input logic [15:0] m, input logic [2:0] e,
                        input logic lvl, input int div, input logic tgl);
        @(posedge clk_i);
        pin_o <= {m, e, lvl};
        repeat (div - 1) begin
            @(posedge clk_i);
            // level mode drops the enable, edge modes hold the level
            pin_o <= {~m, ~e, tgl & lvl};
        end
    endtask
    // quiet edges: data churns, strobe low or held at its level
    task automatic idle(input int n, input logic tgl);
        repeat (n) begin
            @(posedge clk_i);
            pin_o <= {~pin_o.mant, pin_o.gain_range_code, tgl & pin_o.strobe};
        end
    endtask
endmodule

// [verif/sipes_top_bench.sv]
// Purpose: self-checking bench of the sample input port and scaler
// Assumes: wishbone ack comes one cycle after the request is taken
// Notes: expectations queue at send time, a watcher pops them on results
`timescale 1ns/1ns
module sipes_top_bench;
    import sipes_pkg::*;
    logic clk_i = 0, rst_i = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0;
    logic [ADR_W-1:0] wb_adr = '0; // byte address
    logic [3:0] wb_sel = '0;
    logic [31:0] wb_dat = '0, wb_q, rd_dat;
    logic signed [MANT_W-1:0] cos_v, sin_v, smp_o; // oscillator, result
    sipes_sample_s pin;
    sipes_integ_s integ, mdl, ei; // seen, reference and popped sums
    logic valid, chan, done, wb_ack, complex_m = 0;
    logic [7:0] ctrl = '0; // bench copy of the exponent control
    int failures = 0, num_checks = 0;
    logic [16:0] smp_q[$]; // expected scaled sample and channel
    logic [16:0] es; // oldest expected sample popped by the watcher
    sipes_integ_s int_q[$]; // expected integrator sums
    sipes_top sipes_top_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .pin_i(pin), .cos_i(cos_v),
        .sin_i(sin_v), .sample_o(smp_o), .sample_valid_o(valid),
        .channel_a_o(chan), .integ_o(integ), .integ_done_o(done));
    sipes_adc_model sipes_adc_model_inst (.clk_i(clk_i), .pin_o(pin));
    // free-running processing clock
    initial begin
        forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
    end
    // verdict and end of run
    task automatic stop_test();
        if (failures == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // shared tally behind every compare
    task automatic tally(input bit bad, input string n,
                         input logic [79:0] e, g);
        num_checks++;
        if (bad) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_reg(input string n, input logic [31:0] e, g);
        tally(g !== e, n, 80'(e), 80'(g));
    endtask
    task automatic chk_smp(input logic [16:0] e, g);
        tally(g !== e, "sample_o,channel_a_o", 80'(e), 80'(g));
    endtask
    task automatic chk_int(input sipes_integ_s e, g);
        tally(g !== e, "integ_o", e, g);
    endtask
    // classic single wishbone cycle; waits for ack under a bound
    task automatic wb_io(input logic w, input logic [IDX_W-1:0] i,
                         input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1;
        wb_stb <= 1;
        wb_we <= w;
        wb_adr <= {i, 2'b00};
        wb_dat <= d;
        wb_sel <= s;
        // ack and read data are taken at the rising edge that shows ack
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        rd_dat = wb_q;
        wb_cyc <= 0;
        wb_stb <= 0;
    endtask
    task automatic rd_chk(input string n, input logic [IDX_W-1:0] i,
                          input logic [31:0] e, m);
        wb_io(0, i, '0, 4'hf);
        chk_reg(n, e & m, rd_dat & m);
    endtask
    // reference shift from the bench copy of the control fields
    function automatic logic signed [15:0] scl(input logic signed [15:0] m,
                                                input logic [2:0] e);
        logic [2:0] sh;
        sh = ctrl[DIR_BIT] ? EXP_TOP - e + ctrl[BIAS_LSB+:3]
                           : e + ctrl[BIAS_LSB+:3];
        return m >>> sh;
    endfunction
    // note the expected results, then hand the sample to the converter
    task automatic put(input logic [2:0] e, input logic lvl, input int div,
                       input logic tgl);
        logic signed [15:0] m, x;
        m = 16'($urandom);
        x = scl(m, e);
        smp_q.push_back({x, lvl});
        if (!complex_m || lvl) begin
            mdl.i_sum += x * cos_v;
            mdl.q_sum += x * sin_v;
        end else begin
            mdl.i_sum -= x * sin_v;
            mdl.q_sum += x * cos_v;
        end
        if (!complex_m || !lvl) int_q.push_back(mdl);
        sipes_adc_model_inst.send(m, e, lvl, div, tgl);
    endtask
    // watcher: results are read mid-cycle, once settled
    always @(negedge clk_i) begin
        if (valid === 1'b1) begin
            es = 'x;
            if (smp_q.size() != 0) es = smp_q.pop_front();
            chk_smp(es, {smp_o, chan});
        end
        if (done === 1'b1) begin
            ei = 'x;
            if (int_q.size() != 0) ei = int_q.pop_front();
            chk_int(ei, integ);
        end
    end
    // a hang is cut short well past the expected run length
    initial begin
        #(6000 * CLK_PERIOD_NS);
        failures++;
        stop_test();
    end
    initial begin
        void'($urandom(47));
        cos_v = 16'($urandom);
        sin_v = 16'($urandom);
        mdl = '0;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        rd_chk("mode", MODE_IDX, 0, '1);
        rd_chk("ctrl", CTRL_IDX, 32'(CTRL_RST), 'hf0);
        rd_chk("unmapped", 10'h100, 0, '1);
        wb_io(1, CTRL_IDX, 'hf0, 4'h0);
        rd_chk("ctrl", CTRL_IDX, 0, 'hf0);
        // every bias in both directions, all eight codes back to back
        for (int c = 0; c < 16; c++) begin
            ctrl = 8'(c << 4);
            wb_io(1, CTRL_IDX, 32'(ctrl), 4'h1);
            rd_chk("ctrl", CTRL_IDX, 32'(ctrl), 'hf0);
            for (int e = 0; e < 8; e++) begin
                put(3'(e), 1, 1, 0);
            end
            sipes_adc_model_inst.idle(3, 0);
        end
        ctrl = '0;
        wb_io(1, CTRL_IDX, 0, 4'hf);
        // single real at a quarter rate, then the reserved mode code
        for (int k = 0; k < 6; k++) begin
            put(3'($urandom), 1, 4, 0);
        end
        sipes_adc_model_inst.idle(3, 0);
        wb_io(1, MODE_IDX, 3, 4'hf);
        rd_chk("mode", MODE_IDX, 3, '1);
        for (int k = 0; k < 2; k++) put(3'($urandom), 1, 2, 0);
        sipes_adc_model_inst.idle(3, 0);
        // diversity: full rate then a third rate
        wb_io(1, MODE_IDX, 1, 4'hf);
        for (int k = 0; k < 12; k++)
            put(3'($urandom), ~k[0], k < 6 ? 1 : 3, 1);
        sipes_adc_model_inst.idle(3, 1);
        // reset in mid-run, then complex pairs
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        mdl = '0;
        int_q.delete();
        rd_chk("mode", MODE_IDX, 0, '1);
        wb_io(1, MODE_IDX, 2, 4'hf);
        complex_m = 1;
        for (int k = 0; k < 8; k++)
            put(3'($urandom), ~k[0], 2, 1);
        sipes_adc_model_inst.idle(4, 1);
        // four pairs since reset: count eight, last tag quadrature, none held
        rd_chk("status", STAT_IDX, 32'h8 << STAT_CNT_LSB, '1);
        chk_reg("pending", 0, 32'(smp_q.size() + int_q.size()));
        stop_test();
    end
endmodule
